/* File: buck_startup_ocp_sequencer.sv */
// Start-up, soft-start and overcurrent retry sequencer for a buck controller.
// Assumes analog comparators deliver levels synchronous to mclk_in.
//
// Overview of operation
// [RULE1] Bias above power-on threshold leads into the set-point sampling phase.
// [RULE2] Enable pin held low postpones every initialization step until it rises.
// [RULE3] Timing starts when the enable pin crosses the trip level.
// [RULE4] A fixed delay of 6.8 ms precedes set-point sampling.
// [RULE5] During the delay low-side drive is off and sense current flows.
// [RULE6] Sampling lasts zero to 3.4 ms, longer for higher settings.
// [RULE7] The set point lives in a counter feeding a DAC, held while biased; here it is also cleared whenever enable is low.
// [RULE8] Soft-start begins as soon as sampling completes.
// [RULE9] Reference ramps from zero to 0.6 V over 6.8 ms.
// [RULE10] Ramp is 64 equal digital steps at one fixed rate.
// [RULE11] Error amplifier is enabled after a short launch interval.
// [RULE12] Soft-start ends once the ramp passes the final reference.
// [RULE13] Output pre-biased low: switches stay off until ramp passes output.
// [RULE14] Output pre-biased high: switches stay off until soft-start ends.
// [RULE15] Disable then re-enable reruns full initialization with a new sample.
// [RULE16] Overcurrent retries keep the stored set point.
// [RULE17] A trip shuts output off, then two dummy time-outs, then soft-start.
// [RULE18] Monitoring opens 200 ns after low-side rise and closes at its fall.
// [RULE19] Three narrow or missing low-side pulses force a 425 ns third pulse.
// [RULE20] With protection disabled, stretching and insertion are disabled.
// [RULE21] Trip when switch drop exceeds twice the sampled setting voltage.
// [RULE22] Enable low stops the oscillator, drops both gates, re-arms soft-start.
// [RULE23] A setting above the disable limit means no overcurrent protection.
// [RULE24] A trip during real soft-start restarts the two dummy time-outs.
// [RULE25] One time-base tick paces delays, dummy time-outs and ramp steps.
// [RULE26] Bias falling below threshold resets all and discards the set point.
`include "seq_consts.svh"
`default_nettype none
module buck_startup_ocp_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
  parameter int unsigned SP_BITS = `SETPOINT_BITS
) (
  input wire logic mclk_in,                    // System clock, 125 MHz.
  input wire logic reset_n_in,                 // Asynchronous reset, active low.
  input wire logic bias_por_ok_in,             // Bias supply above power-on level.
  input wire logic enable_above_trip_in,       // Enable pin above shutdown trip.
  input wire logic pwm_low_req_in,             // Internal PWM low-side request.
  input wire logic pwm_high_req_in,            // Internal PWM high-side request.
  input wire logic pwm_cycle_start_in,         // Oscillator period start pulse.
  input wire logic trip_sense_above_dac_in,    // Set-point DAC reached sense pin.
  input wire logic switch_node_overdrop_in,    // Switch drop above trip threshold.
  input wire logic ramp_above_output_in,       // Ramp reference above sensed output.
  input wire logic output_above_target_in,     // Sensed output above final target.
  output logic low_side_gate_drive_out,        // Low-side gate command.
  output logic high_side_gate_drive_out,       // High-side gate command.
  output logic trip_sense_current_en_out,      // Sense current source enable.
  output logic [SP_BITS-1:0] setpoint_dac_out, // Held overcurrent set point.
  output logic [SP_BITS:0] trip_threshold_out, // Doubled set point for trip compare.
  output logic [6:0] reference_dac_out,        // Soft-start reference step code.
  output logic error_amp_en_out,               // Error amplifier output enable.
  output logic osc_run_out,                    // Oscillator run.
  output logic soft_start_done_out,            // Soft-start complete.
  output logic ocp_active_out,                 // Overcurrent protection armed.
  output logic hiccup_out                      // Retry time-out in progress.
);
  localparam int unsigned TB_W = $clog2(TICK_CYCLES + 1);

  pulse_guard_if gi ();

  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [TB_W-1:0] tick_cnt_ff;
  logic [6:0] seq_cnt_ff;
  logic [6:0] ramp_code_ff;
  logic [1:0] dummy_cnt_ff;
  logic [SP_BITS-1:0] setpoint_ff;
  logic ocp_en_ff;
  logic ramp_passed_ff;
  logic prebias_high_ff;
  logic lo_gate_ff;
  logic hi_gate_ff;
  logic tick;
  logic trip;
  logic sp_full;
  logic in_soft_start;
  logic sw_allow;
  logic state_change;

  assign tick = tick_cnt_ff == TB_W'(TICK_CYCLES - 1);
  assign trip = gi.trip & ocp_en_ff;
  assign sp_full = &setpoint_ff;
  assign in_soft_start = (state_ff == ST_SS_INIT) || (state_ff == ST_SS_RAMP);
  assign state_change = nxt_state != state_ff;
  // Switching waits for the ramp to pass a low pre-bias, or for the end of soft-start.
  assign sw_allow = (state_ff == ST_RUN) ||
                    ((state_ff == ST_SS_RAMP) && ramp_passed_ff &&
                     !prebias_high_ff);  // [RULE13] [RULE14]

  // One time base paces every phase; it stands still while shut down.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_cnt_ff <= '0;
    end else if (state_ff == ST_OFF || tick) begin
      tick_cnt_ff <= '0;  // [RULE25] [RULE3]
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;  // [RULE25]
    end
  end

  always_comb begin
    nxt_state = state_ff;
    if (!bias_por_ok_in || !enable_above_trip_in) begin
      nxt_state = ST_OFF;  // [RULE26] [RULE22] [RULE2]
    end else begin
      unique case (state_ff)
        ST_OFF: begin
          nxt_state = ST_DELAY;  // [RULE1] [RULE3]
        end
        ST_DELAY: begin
          if (tick && seq_cnt_ff == 7'(`INIT_DELAY_TICKS - 1)) begin
            nxt_state = ST_SAMPLE;  // [RULE4]
          end
        end
        ST_SAMPLE: begin
          if (trip_sense_above_dac_in || sp_full) begin
            nxt_state = ST_SS_INIT;  // [RULE8] [RULE6]
          end
        end
        ST_SS_INIT: begin
          if (trip) begin
            nxt_state = ST_HICCUP;  // [RULE24]
          end else if (tick && seq_cnt_ff == 7'(`EA_INIT_TICKS - 1)) begin
            nxt_state = ST_SS_RAMP;  // [RULE11]
          end
        end
        ST_SS_RAMP: begin
          if (trip) begin
            nxt_state = ST_HICCUP;  // [RULE24]
          end else if (tick && ramp_code_ff == 7'(`SS_STEPS)) begin
            nxt_state = ST_RUN;  // [RULE12]
          end
        end
        ST_RUN: begin
          if (trip) begin
            nxt_state = ST_HICCUP;  // [RULE17]
          end
        end
        ST_HICCUP: begin
          if (tick && seq_cnt_ff == 7'(`SS_STEPS - 1) &&
              dummy_cnt_ff == 2'(`DUMMY_TIMEOUTS - 1)) begin
            nxt_state = ST_SS_INIT;  // [RULE17] [RULE16]
          end
        end
        default: begin
          nxt_state = ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ticks within a phase; in retry it wraps once per dummy time-out.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seq_cnt_ff <= '0;
    end else if (state_change) begin
      seq_cnt_ff <= '0;
    end else if (tick) begin
      if (state_ff == ST_HICCUP && seq_cnt_ff == 7'(`SS_STEPS - 1)) begin
        seq_cnt_ff <= '0;  // [RULE25]
      end else begin
        seq_cnt_ff <= seq_cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dummy_cnt_ff <= '0;
    end else if (state_ff != ST_HICCUP) begin
      dummy_cnt_ff <= '0;  // [RULE24]
    end else if (tick && seq_cnt_ff == 7'(`SS_STEPS - 1)) begin
      dummy_cnt_ff <= dummy_cnt_ff + 1'b1;  // [RULE17]
    end
  end

  // Reference ramp: one equal step per tick from launch, held at full scale.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ramp_code_ff <= '0;
    end else if (!in_soft_start && state_ff != ST_RUN) begin
      ramp_code_ff <= '0;  // [RULE22]
    end else if (in_soft_start && tick && ramp_code_ff != 7'(`SS_STEPS)) begin
      ramp_code_ff <= ramp_code_ff + 1'b1;  // [RULE9] [RULE10]
    end
  end

  // Set point counts up one code per tick until the DAC meets the sense pin.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      setpoint_ff <= '0;
    end else if (state_ff == ST_OFF || nxt_state == ST_OFF) begin
      setpoint_ff <= '0;  // [RULE26] [RULE15]
    end else if (state_ff == ST_SAMPLE && tick && !trip_sense_above_dac_in &&
                 !sp_full) begin
      setpoint_ff <= setpoint_ff + 1'b1;  // [RULE6] [RULE7]
    end
  end

  // A sample that never met the pin, or one above the limit, disarms protection.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ocp_en_ff <= 1'b0;
    end else if (state_ff == ST_OFF) begin
      ocp_en_ff <= 1'b0;  // [RULE26]
    end else if (state_ff == ST_SAMPLE && nxt_state == ST_SS_INIT) begin
      ocp_en_ff <= trip_sense_above_dac_in &&
                   (setpoint_ff <= SP_BITS'(`OCP_DISABLE_CODE));  // [RULE23]
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ramp_passed_ff <= 1'b0;
      prebias_high_ff <= 1'b0;
    end else if (!in_soft_start) begin
      ramp_passed_ff <= 1'b0;
      prebias_high_ff <= output_above_target_in;  // [RULE14]
    end else if (ramp_above_output_in) begin
      ramp_passed_ff <= 1'b1;  // [RULE13]
    end
  end

  // Gate commands drop on the edge after a trip or shutdown.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lo_gate_ff <= 1'b0;
      hi_gate_ff <= 1'b0;
    end else if (!sw_allow || trip || state_change) begin
      lo_gate_ff <= 1'b0;  // [RULE17] [RULE22] [RULE5]
      hi_gate_ff <= 1'b0;
    end else begin
      lo_gate_ff <= gi.lo_gate;
      hi_gate_ff <= pwm_high_req_in && !gi.lo_gate && !gi.force_on;  // [RULE19]
    end
  end

  assign gi.lo_req = pwm_low_req_in & sw_allow;
  assign gi.cycle_start = pwm_cycle_start_in;
  assign gi.overdrop = switch_node_overdrop_in;  // [RULE21]
  assign gi.enable = sw_allow;
  assign gi.ocp_en = ocp_en_ff;  // [RULE20]

  low_side_pulse_guard #(
    .MON_DELAY(`MON_DELAY_CYCLES),
    .MIN_WIDTH(`MIN_PULSE_CYCLES)
  ) u_guard (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .gi(gi.guard)
  );

  assign low_side_gate_drive_out = lo_gate_ff;
  assign high_side_gate_drive_out = hi_gate_ff;
  assign trip_sense_current_en_out = (state_ff == ST_DELAY) ||
                                     (state_ff == ST_SAMPLE);  // [RULE5]
  assign setpoint_dac_out = setpoint_ff;  // [RULE7]
  assign trip_threshold_out = {setpoint_ff, 1'b0};  // [RULE21]
  assign reference_dac_out = ramp_code_ff;
  assign error_amp_en_out = (state_ff == ST_SS_RAMP) ||
                            (state_ff == ST_RUN);  // [RULE11]
  assign osc_run_out = state_ff != ST_OFF;  // [RULE22]
  assign soft_start_done_out = state_ff == ST_RUN;  // [RULE12]
  assign ocp_active_out = ocp_en_ff;
  assign hiccup_out = state_ff == ST_HICCUP;
endmodule : buck_startup_ocp_sequencer
`default_nettype wire

/* File: low_side_pulse_guard.sv */
// Low-side gate monitoring window, minimum-pulse stretching and trip detect.
// Assumes one clock and a cycle-start pulse from the oscillator once per period.
`include "seq_consts.svh"
`default_nettype none
module low_side_pulse_guard
  import seq_pkg::*;
#(
  parameter int unsigned MON_DELAY = `MON_DELAY_CYCLES,
  parameter int unsigned MIN_WIDTH = `MIN_PULSE_CYCLES
) (
  input wire logic mclk_in,      // System clock.
  input wire logic reset_n_in,   // Asynchronous reset, active low.
  pulse_guard_if.guard gi        // Link to the sequencer core.
);
  localparam int unsigned W = $clog2(MIN_WIDTH + MON_DELAY + 1);

  logic [W-1:0] width_cnt_ff;
  logic [W-1:0] mon_cnt_ff;
  logic [W-1:0] force_cnt_ff;
  logic [1:0] narrow_cnt_ff;
  logic force_ff;
  logic gate;
  logic narrow;

  assign gate = gi.lo_req | force_ff;
  assign narrow = width_cnt_ff < W'(MIN_WIDTH);
  assign gi.lo_gate = gate;
  assign gi.force_on = force_ff;
  // Trips count only inside the window that opens after the settle delay.
  assign gi.trip = gi.enable & gi.ocp_en & gate & gi.overdrop &
                   (mon_cnt_ff == W'(MON_DELAY));  // [RULE18] [RULE21]

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mon_cnt_ff <= '0;
    end else if (!gate) begin
      mon_cnt_ff <= '0;  // [RULE18]
    end else if (mon_cnt_ff != W'(MON_DELAY)) begin
      mon_cnt_ff <= mon_cnt_ff + 1'b1;  // [RULE18]
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      width_cnt_ff <= '0;
    end else if (!gi.enable || gi.cycle_start) begin
      width_cnt_ff <= '0;
    end else if (gate && narrow) begin
      width_cnt_ff <= width_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      narrow_cnt_ff <= '0;
    end else if (!gi.enable || !gi.ocp_en) begin
      narrow_cnt_ff <= '0;  // [RULE20]
    end else if (gi.cycle_start) begin
      if (force_ff || !narrow || narrow_cnt_ff == 2'(`NARROW_LIMIT - 2)) begin
        narrow_cnt_ff <= '0;
      end else begin
        narrow_cnt_ff <= narrow_cnt_ff + 1'b1;  // [RULE19]
      end
    end
  end

  // The third narrow or missing pulse is forced on from the cycle start.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      force_ff <= 1'b0;
      force_cnt_ff <= '0;
    end else if (!gi.enable || !gi.ocp_en) begin
      force_ff <= 1'b0;  // [RULE20]
      force_cnt_ff <= '0;
    end else if (gi.cycle_start && !force_ff && narrow &&
                 narrow_cnt_ff == 2'(`NARROW_LIMIT - 2)) begin
      force_ff <= 1'b1;  // [RULE19]
      force_cnt_ff <= W'(1);
    end else if (force_ff) begin
      if (force_cnt_ff == W'(MIN_WIDTH)) begin
        force_ff <= 1'b0;
        force_cnt_ff <= '0;
      end else begin
        force_cnt_ff <= force_cnt_ff + 1'b1;  // [RULE19]
      end
    end
  end
endmodule : low_side_pulse_guard
`default_nettype wire

/* File: power_stage_model.sv */
// Power stage, output node, setting resistor and enable pull-down seen by the sequencer.
// Assumes the sequencer's clock and codes chosen by the bench.
`default_nettype none
module power_stage_model (
  input wire logic mclk_in,           // Clock.
  input wire logic low_gate_in,       // Low-side gate.
  input wire logic pull_down_in,      // Hold enable low.
  input wire logic short_in,          // Output shorted.
  input wire logic [4:0] set_code_in, // Setting resistor as DAC code.
  input wire logic [4:0] dac_in,      // Set-point DAC.
  input wire logic [6:0] ref_in,      // Ramp code.
  input wire logic [6:0] vout_in,     // Output level as ramp code.
  output logic enable_out,            // Enable above trip.
  output logic overdrop_out,          // Switch drop over threshold.
  output logic dac_above_out,         // DAC reached sense pin.
  output logic ramp_above_out,        // Ramp above output.
  output logic out_high_out           // Output above target.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] rise_ff;
  // A released enable pin charges slowly, so the trip level is crossed some cycles later.
  always_ff @(posedge mclk_in) begin
    rise_ff <= pull_down_in ? 3'h0 : (rise_ff == 3'h7 ? rise_ff : rise_ff + 3'h1);
  end
  assign enable_out = (rise_ff == 3'h7);
  assign overdrop_out = short_in && low_gate_in;
  assign dac_above_out = (dac_in >= set_code_in);
  assign ramp_above_out = (ref_in > vout_in);
  assign out_high_out = (vout_in > 7'h40);
endmodule : power_stage_model
`default_nettype wire

/* File: pulse_guard_if.sv */
// Carrier between the sequencer core and the low-side pulse guard.
// Assumes both ends run on the same clock.
`default_nettype none
interface pulse_guard_if;
  logic lo_req;
  logic cycle_start;
  logic overdrop;
  logic enable;
  logic ocp_en;
  logic lo_gate;
  logic force_on;
  logic trip;
  modport core (output lo_req, cycle_start, overdrop, enable, ocp_en,
                input lo_gate, force_on, trip);
  modport guard (input lo_req, cycle_start, overdrop, enable, ocp_en,
                 output lo_gate, force_on, trip);
endinterface : pulse_guard_if
`default_nettype wire

/* File: seq_checker_assertions.sv */
// Concurrent checks on the sequencer's top-level ports.
// Assumes the bind at the foot of this file attaches it to every sequencer.
`default_nettype none
module seq_checker #(
  parameter int unsigned SP_BITS = 5
) (
  input wire logic mclk_in,                    // Clock.
  input wire logic reset_n_in,                 // Reset, active low.
  input wire logic bias_por_ok_in,             // Bias good.
  input wire logic enable_above_trip_in,       // Enable above trip.
  input wire logic switch_node_overdrop_in,    // Switch drop high.
  input wire logic low_side_gate_drive_out,    // Low gate.
  input wire logic high_side_gate_drive_out,   // High gate.
  input wire logic trip_sense_current_en_out,  // Sense current.
  input wire logic [SP_BITS-1:0] setpoint_dac_out, // Set point.
  input wire logic [SP_BITS:0] trip_threshold_out, // Trip threshold.
  input wire logic [6:0] reference_dac_out,    // Ramp code.
  input wire logic error_amp_en_out,           // Error amp enable.
  input wire logic osc_run_out,                // Oscillator run.
  input wire logic soft_start_done_out,        // Soft-start done.
  input wire logic ocp_active_out,             // Protection armed.
  input wire logic hiccup_out                  // Retry time-out.
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  enable_off_a: assert property (!enable_above_trip_in |=> !osc_run_out &&
    !low_side_gate_drive_out && !high_side_gate_drive_out) else $error("enable low ignored");
  bias_loss_a: assert property (!bias_por_ok_in |=> !osc_run_out &&
    setpoint_dac_out == '0) else $error("bias loss kept state");
  sense_gate_a: assert property (trip_sense_current_en_out |-> !low_side_gate_drive_out &&
    !high_side_gate_drive_out) else $error("gate on while sensing");
  delay_entry_a: assert property ($rose(osc_run_out) |-> trip_sense_current_en_out &&
    reference_dac_out == 7'h00) else $error("bad start of delay");
  setpoint_hold_a: assert property (osc_run_out && $past(osc_run_out) &&
    !trip_sense_current_en_out && !$past(trip_sense_current_en_out) |-> $stable(setpoint_dac_out))
    else $error("set point moved");
  threshold_double_a: assert property (trip_threshold_out == {setpoint_dac_out, 1'b0})
    else $error("threshold not doubled");
  ramp_step_a: assert property ($changed(reference_dac_out) |-> reference_dac_out == 7'h00 ||
    reference_dac_out == $past(reference_dac_out) + 7'h01) else $error("ramp jumped");
  done_level_a: assert property (soft_start_done_out |-> reference_dac_out == 7'h40 &&
    error_amp_en_out) else $error("done before full ramp");
  hiccup_quiet_a: assert property (hiccup_out |-> !low_side_gate_drive_out &&
    !high_side_gate_drive_out) else $error("gate on in retry");
  trip_cause_a: assert property ($rose(hiccup_out) |-> $past(low_side_gate_drive_out) &&
    $past(switch_node_overdrop_in) && $past(ocp_active_out)) else $error("retry without trip");
endmodule : seq_checker
bind buck_startup_ocp_sequencer seq_checker #(.SP_BITS(SP_BITS)) chk (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .bias_por_ok_in(bias_por_ok_in),
  .enable_above_trip_in(enable_above_trip_in), .switch_node_overdrop_in(switch_node_overdrop_in),
  .low_side_gate_drive_out(low_side_gate_drive_out),
  .high_side_gate_drive_out(high_side_gate_drive_out),
  .trip_sense_current_en_out(trip_sense_current_en_out), .setpoint_dac_out(setpoint_dac_out),
  .trip_threshold_out(trip_threshold_out), .reference_dac_out(reference_dac_out),
  .error_amp_en_out(error_amp_en_out), .osc_run_out(osc_run_out),
  .soft_start_done_out(soft_start_done_out), .ocp_active_out(ocp_active_out),
  .hiccup_out(hiccup_out));
`default_nettype wire

/* File: seq_consts.svh */
// Timing and code constants for the buck start-up and protection sequencer.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

`define CLK_PERIOD_NS 8
`define SS_TIME_NS 6800000
`define SS_STEPS 64
`define TICK_CYCLES (`SS_TIME_NS / (`SS_STEPS * `CLK_PERIOD_NS))
`define INIT_DELAY_TICKS 64
`define EA_INIT_TICKS 1
`define DUMMY_TIMEOUTS 2
`define SETPOINT_BITS 5
`define OCP_DISABLE_CODE 30
`define MON_DELAY_NS 200
`define MON_DELAY_CYCLES ((`MON_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_PULSE_NS 425
`define MIN_PULSE_CYCLES ((`MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NARROW_LIMIT 3

`endif

/* File: seq_pkg.sv */
// Types shared by the sequencer and its low-side pulse guard.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_DELAY = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_SS_INIT = 3'h2,
    ST_SS_RAMP = 3'h6,
    ST_RUN = 3'h7,
    ST_HICCUP = 3'h5
  } seq_state_t;
endpackage : seq_pkg
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the start-up and protection sequencer.
// Assumes a short time-base tick so that whole sequences run quickly.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned TICK = 8;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic bias = 1'b1, pull_down = 1'b1, short_cmd = 1'b0, low_req = 1'b1, high_req = 1'b0;
  logic cyc = 1'b0;
  logic [6:0] per_ff = 7'h00;
  logic [4:0] set_code = 5'h05;
  logic [6:0] vout = 7'h00;
  logic low_gate, high_gate, sense_en, ea_en, osc, done, ocp, hic;
  logic en_trip, overdrop, dac_above, ramp_above, out_high;
  logic [4:0] sp;
  logic [5:0] thr;
  logic [6:0] ref_code;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  buck_startup_ocp_sequencer #(.TICK_CYCLES(TICK)) dut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .bias_por_ok_in(bias),
    .enable_above_trip_in(en_trip), .pwm_low_req_in(low_req), .pwm_high_req_in(high_req),
    .pwm_cycle_start_in(cyc), .trip_sense_above_dac_in(dac_above),
    .switch_node_overdrop_in(overdrop), .ramp_above_output_in(ramp_above),
    .output_above_target_in(out_high), .low_side_gate_drive_out(low_gate),
    .high_side_gate_drive_out(high_gate), .trip_sense_current_en_out(sense_en),
    .setpoint_dac_out(sp), .trip_threshold_out(thr), .reference_dac_out(ref_code),
    .error_amp_en_out(ea_en), .osc_run_out(osc), .soft_start_done_out(done),
    .ocp_active_out(ocp), .hiccup_out(hic));
  power_stage_model stage (
    .mclk_in(mclk_in), .low_gate_in(low_gate), .pull_down_in(pull_down), .short_in(short_cmd),
    .set_code_in(set_code), .dac_in(sp), .ref_in(ref_code), .vout_in(vout),
    .enable_out(en_trip), .overdrop_out(overdrop), .dac_above_out(dac_above),
    .ramp_above_out(ramp_above), .out_high_out(out_high));
  always #4 mclk_in = ~mclk_in;
  // Oscillator period of 100 clocks, start pulse in the first cycle.
  always @(posedge mclk_in) begin
    per_ff <= (per_ff == 7'h63) ? 7'h00 : per_ff + 7'h01;
    cyc <= (per_ff == 7'h63);
  end
  task automatic finish_test();
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge mclk_in) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc_n(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask : cyc_n
  // Waits, bounded, for osc (0), sense (1), done (2) or retry (3) to reach a level.
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int n);
    logic [3:0] s;
    #1;
    n = 0;
    s = {hic, done, sense_en, osc};
    while (s[sel] !== lvl && n < lim) begin
      cyc_n(1);
      n = n + 1;
      s = {hic, done, sense_en, osc};
    end
    if (s[sel] !== lvl) mismatches = mismatches + 1;
  endtask : wait_sig
  task automatic start_up(input logic [4:0] k, input logic [6:0] v);
    int n;
    @(posedge mclk_in);
    set_code <= k;
    vout <= v;
    pull_down <= 1'b0;
    wait_sig(0, 1'b1, 40, n);
    check({sense_en, low_gate}, 2'h2);
    cyc_n(500);
    check({sense_en, sp}, 6'h20);
    wait_sig(1, 1'b0, 400, n);
    check(n + 500 >= 504 + 8 * k && n + 500 <= 528 + 8 * k, 1'b1);
    check(sp, k);
    check(ocp, k <= 5'h1e);
    n = 0;
    while (done !== 1'b1 && n < 700) begin
      if (ref_code <= v) check(low_gate, 1'b0);
      cyc_n(1);
      n = n + 1;
    end
    check(n >= 512 && n <= 536, 1'b1);
    check({ea_en, ref_code}, 8'hc0);
    cyc_n(3);
    check(low_gate, 1'b1);
  endtask : start_up
  // Missing low-side pulses over nine periods; counts the forced on-time.
  task automatic stretch(input int exp_hi);
    int hi;
    hi = 0;
    do @(posedge mclk_in); while (cyc !== 1'b1);
    low_req <= 1'b0;
    high_req <= 1'b1;
    cyc_n(5);
    repeat (895) begin
      hi = hi + (low_gate === 1'b1);
      cyc_n(1);
    end
    check(hi, exp_hi);
    @(posedge mclk_in);
    low_req <= 1'b1;
    high_req <= 1'b0;
  endtask : stretch
  task automatic overcurrent();
    int n;
    @(posedge mclk_in);
    vout <= 7'h00;
    short_cmd <= 1'b1;
    wait_sig(3, 1'b1, 60, n);
    check({hic, low_gate, high_gate, done}, 4'h8);
    wait_sig(3, 1'b0, 1100, n);
    check(n >= 1012 && n <= 1032, 1'b1);
    check(sp, set_code);
    wait_sig(3, 1'b1, 700, n);
    check(hic, 1'b1);
    @(posedge mclk_in);
    short_cmd <= 1'b0;
    wait_sig(3, 1'b0, 1100, n);
    wait_sig(2, 1'b1, 700, n);
    check({done, sp}, 6'h25);
  endtask : overcurrent
  task automatic shut_down();
    @(posedge mclk_in);
    pull_down <= 1'b1;
    cyc_n(3);
    check({osc, low_gate, high_gate, done, ref_code}, 11'h000);
  endtask : shut_down
  initial begin
    int n;
    cyc_n(11);
    check({osc, low_gate, sp, ref_code}, 11'h000);
    @(posedge mclk_in);
    reset_n_in <= 1'b1;
    cyc_n(40);
    check(osc, 1'b0);
    start_up(5'h05, 7'h20);
    stretch(162);
    overcurrent();
    shut_down();
    start_up(5'h09, 7'h46);
    shut_down();
    start_up(5'h1f, 7'h00);
    stretch(0);
    @(posedge mclk_in);
    short_cmd <= 1'b1;
    cyc_n(300);
    check(hic, 1'b0);
    @(posedge mclk_in);
    short_cmd <= 1'b0;
    bias <= 1'b0;
    cyc_n(3);
    check({osc, sp}, 6'h00);
    @(posedge mclk_in);
    bias <= 1'b1;
    wait_sig(0, 1'b1, 10, n);
    check({osc, sense_en}, 2'h3);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
